// file: tb/hpc_port_power_chk.sv
module hpc_port_power_chk #(
  parameter NP = 4
) (
  input logic          mclk_i,
  input logic          reset_n_i,
  input logic          power_mode_select_i,
  input logic          upstream_vbus_monitor_i,
  input logic          suspend_i,
  input logic          global_oc_mode_i,
  input logic [NP-1:0] overcurrent_in_n_i,
  input logic [NP-1:0] port_power_req_i,
  input logic [NP-1:0] power_enable_n_o,
  input logic [NP-1:0] power_enable_oe_o,
  input logic [NP-1:0] port_led_n_o,
  input logic [NP-1:0] overcurrent_o,
  input logic [NP-1:0] nonremovable_o,
  input logic          rom_chip_select_n_o,
  input logic          self_powered_o,
  input logic          ganged_o,
  input logic          rom_mode_o,
  input logic [2:0]    port_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // straps frozen once the power pins are driven
  wire on_w = power_enable_oe_o[0];
  // four cycles covers the two sync flops and the output flop
  property p_self;
    (on_w && power_mode_select_i && upstream_vbus_monitor_i)[*4]
      |-> self_powered_o;
  endproperty
  a_self: assert property (p_self) else $error("not self powered");
  property p_bus;
    (on_w && !power_mode_select_i)[*4] |-> !self_powered_o;
  endproperty
  a_bus: assert property (p_bus) else $error("not bus powered");
  property p_oc;
    (on_w && !global_oc_mode_i && !overcurrent_in_n_i[0])[*4]
      |-> overcurrent_o[0];
  endproperty
  a_oc: assert property (p_oc) else $error("port oc missed");
  property p_goc;
    (on_w && global_oc_mode_i &&
      overcurrent_in_n_i == {{(NP-1){1'b1}}, 1'b0})[*4]
      |-> overcurrent_o[1:0] == 2'b11;
  endproperty
  a_goc: assert property (p_goc) else $error("global oc missed");
  property p_pwr;
    (on_w && port_power_req_i[0] && &overcurrent_in_n_i)[*4]
      |-> !power_enable_n_o[0];
  endproperty
  a_pwr: assert property (p_pwr) else $error("port power off");
  property p_cnt;
    on_w && $past(on_w, 3) && port_count_o == 3'd2
      |-> &power_enable_n_o[NP-1:2];
  endproperty
  a_cnt: assert property (p_cnt) else $error("unused port on");
  property p_strap;
    on_w && $past(on_w, 3) |-> $stable({port_count_o, ganged_o,
      rom_mode_o, nonremovable_o});
  endproperty
  a_strap: assert property (p_strap) else $error("strap moved");
  property p_cs;
    !rom_chip_select_n_o |-> rom_mode_o;
  endproperty
  a_cs: assert property (p_cs) else $error("select in led mode");
  property p_led;
    (rom_mode_o && suspend_i)[*4] |-> !port_led_n_o[0];
  endproperty
  a_led: assert property (p_led) else $error("no suspend led");
endmodule

bind hpc_port_power hpc_port_power_chk #(.NP(NP)) i_chk (
  .mclk_i, .reset_n_i, .power_mode_select_i, .upstream_vbus_monitor_i,
  .suspend_i, .global_oc_mode_i, .overcurrent_in_n_i, .port_power_req_i,
  .power_enable_n_o, .power_enable_oe_o, .port_led_n_o, .overcurrent_o,
  .nonremovable_o, .rom_chip_select_n_o, .self_powered_o, .ganged_o,
  .rom_mode_o, .port_count_o);

// file: tb/hpc_rom_model.sv
module hpc_rom_model (
  input  logic        cs_n_i,
  input  logic        sck_i,
  input  logic        mosi_i,
  output logic        miso_o = 1'b0,
  output logic [31:0] cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int          n = 0;
  logic [15:0] w;
  // command and address shift in msb first on rising clock
  always @(posedge sck_i or posedge cs_n_i)
    if (cs_n_i) n <= 0;
    else begin
      if (n < 32) cmd_o <= {cmd_o[30:0], mosi_i};
      n <= n + 1;
    end
  // data moves on the falling edge so it is settled at the next rise
  always @(negedge sck_i or posedge cs_n_i) begin
    w = 16'hc3a0 + 16'((n - 32) / 16);
    if (cs_n_i) miso_o <= ~miso_o; // released line flips the last bit it drove
    else if (n >= 32) miso_o <= w[15 - (n - 32) % 16];
  end
endmodule

// file: tb/test_hpc_port_power.sv
module test_hpc_port_power;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, suspend_i = 1'b0;
  logic power_mode_select_i = 1'b0, upstream_vbus_monitor_i = 1'b0;
  logic rom_cs_strap_i = 1'b0, global_oc_mode_i = 1'b0;
  logic [3:0] overcurrent_in_n_i = 4'hf, power_strap_i = 4'hf;
  logic [3:0] port_power_req_i = 4'h0, port_active_i = 4'h0;
  logic rom_chip_select_n_o, rom_chip_select_oe_o, rom_serial_clock_o;
  logic rom_data_out_o, rom_data_in_i, sys_suspend_clk_o, self_powered_o;
  logic ganged_o, rom_mode_o, cfg_valid_o;
  logic [3:0] power_enable_n_o, power_enable_oe_o, port_led_n_o;
  logic [3:0] overcurrent_o, nonremovable_o;
  logic [2:0] port_count_o;
  logic [15:0] vendor_id_o, product_id_o, unique_id_o, hub_cfg_o;
  logic [31:0] cmd;
  int n_errors = 0, comparisons = 0, cyc_n = 0, k;

  hpc_port_power i_dut (.mclk_i, .reset_n_i, .ce_i, .power_mode_select_i,
    .upstream_vbus_monitor_i, .overcurrent_in_n_i, .power_strap_i,
    .power_enable_n_o, .power_enable_oe_o, .rom_cs_strap_i,
    .rom_chip_select_n_o, .rom_chip_select_oe_o, .rom_serial_clock_o,
    .rom_data_out_o, .rom_data_in_i, .port_led_n_o, .sys_suspend_clk_o,
    .port_power_req_i, .port_active_i, .suspend_i, .global_oc_mode_i,
    .self_powered_o, .overcurrent_o, .nonremovable_o, .port_count_o,
    .ganged_o, .rom_mode_o, .cfg_valid_o, .vendor_id_o, .product_id_o,
    .unique_id_o, .hub_cfg_o);
  hpc_rom_model i_rom (.cs_n_i(rom_chip_select_n_o),
    .sck_i(rom_serial_clock_o), .mosi_i(rom_data_out_o),
    .miso_o(rom_data_in_i), .cmd_o(cmd));

  initial forever #5 mclk_i = ~mclk_i;

  task automatic complete_run;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // count changes of the system pin over twenty cycles
  task automatic clk_changes(input int exp);
    int chg = 0;
    logic last;
    last = sys_suspend_clk_o;
    repeat (20) begin
      wt(1);
      chg += (sys_suspend_clk_o != last);
      last = sys_suspend_clk_o;
    end
    check(chg, exp);
  endtask
  // straps ride through reset and past the capture edge
  task automatic boot(input logic [3:0] ps, input logic cs,
                      input logic [3:0] oc);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    power_strap_i <= ps;
    rom_cs_strap_i <= cs;
    overcurrent_in_n_i <= oc;
    wt(20);
    check(power_enable_oe_o, 4'h0);
    check(power_enable_n_o, 4'hf);
    check(rom_chip_select_oe_o, 1'b0);
    reset_n_i <= 1'b1;
    wt(10);
    overcurrent_in_n_i <= 4'hf;
    wt(2);
    check(power_enable_oe_o, 4'hf);
    check(rom_chip_select_oe_o, 1'b1);
  endtask

  // hang guard, well above two rom reads plus three boots
  always @(posedge mclk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    boot(4'hf, 1'b0, 4'h7);
    check(port_count_o, 3'd4);
    check(ganged_o, 1'b0);
    check(rom_mode_o, 1'b1);
    check(nonremovable_o, 4'h8);
    for (k = 0; k < 4000 && cfg_valid_o !== 1'b1; k++) wt(1);
    check(cmd, 32'h0300_0000);
    check({vendor_id_o, product_id_o}, 32'hc3a0_c3a1);
    check({unique_id_o, hub_cfg_o}, 32'hc3a2_c3a3);
    port_power_req_i <= 4'h5;
    wt(5);
    check(power_enable_n_o, 4'ha);
    overcurrent_in_n_i <= 4'he;
    wt(5);
    check(overcurrent_o, 4'h1);
    global_oc_mode_i <= 1'b1;
    wt(5);
    check(overcurrent_o, 4'hf);
    overcurrent_in_n_i <= 4'hf;
    global_oc_mode_i <= 1'b0;
    for (k = 0; k < 4; k++) begin
      {power_mode_select_i, upstream_vbus_monitor_i} <= k[1:0];
      wt(5);
      check(self_powered_o, k == 3);
    end
    suspend_i <= 1'b1;
    wt(5);
    check({port_led_n_o[0], sys_suspend_clk_o}, 2'b01);
    suspend_i <= 1'b0;
    // led mode, three ports, ganged, device clock on
    boot(4'h8, 1'b1, 4'hf);
    check({port_count_o, ganged_o, rom_mode_o}, 5'b01110);
    port_power_req_i <= 4'h1;
    port_active_i <= 4'h3;
    wt(5);
    check(cfg_valid_o, 1'b1);
    check(power_enable_n_o, 4'h8);
    check(port_led_n_o, 4'hc);
    check(rom_chip_select_n_o, 1'b1);
    clk_changes(20);
    // two ports, rom mode, clock rate taken from the rom's config bit
    boot(4'h2, 1'b0, 4'hf);
    port_power_req_i <= 4'hf;
    for (k = 0; k < 4000 && cfg_valid_o !== 1'b1; k++) wt(1);
    check(port_count_o, 3'd2);
    check(power_enable_n_o, 4'hc);
    clk_changes(10);
    complete_run();
  end
endmodule

// file: verilog/hpc_map.vh
// Notes on behaviour
// - power select low bus, high self
// - over-current inputs are active low
// - over-current pins strap non-removable ports
// - power enable low means vbus on
// - port4/port3 power straps pick 2/3/4 ports
// - port2 power strap picks ganged/individual
// - port1 power strap enables 24/12 MHz clock
// - over-current per port or global
// - chip-select strap picks rom or leds
// - port1 led pin: led or suspend
// - rom mode: spi master drives clock, select, data
// - rom read yields ids and settings
// - vbus monitor switches self/bus power behaviour
// - system output: suspend or device clock
// - per-port status led in led mode
`ifndef HPC_MAP_VH
`define HPC_MAP_VH
`define HPC_NUM_PORTS     4
`define HPC_ROM_WORDS     16
`define HPC_ROM_CMD_READ  8'h03
`define HPC_SCK_DIV       4
`define HPC_CLK_DIV_24    2'h1
`define HPC_CLK_DIV_12    2'h2
`define HPC_VID_IDX       0
`define HPC_PID_IDX       1
`define HPC_UID_IDX       2
`define HPC_CFG_IDX       3
`endif

// file: verilog/hpc_port_power.v
`include "hpc_map.vh"
// board-facing hub port power, strap and led control
module hpc_port_power #(
  parameter NP = `HPC_NUM_PORTS
) (
  // clock and reset
  input  wire          mclk_i,
  input  wire          reset_n_i,
  input  wire          ce_i,
  // system pins
  input  wire          power_mode_select_i,
  input  wire          upstream_vbus_monitor_i,
  // port pins; power pins double as straps, captured on the fourth clock after reset
  input  wire [NP-1:0] overcurrent_in_n_i,
  input  wire [NP-1:0] power_strap_i,
  output reg  [NP-1:0] power_enable_n_o,
  output reg  [NP-1:0] power_enable_oe_o,
  // shared rom / led pins
  input  wire          rom_cs_strap_i,
  output reg           rom_chip_select_n_o,
  output reg           rom_chip_select_oe_o,
  output reg           rom_serial_clock_o,
  output reg           rom_data_out_o,
  input  wire          rom_data_in_i,
  output reg  [NP-1:0] port_led_n_o,
  output reg           sys_suspend_clk_o,
  // hub core side
  input  wire [NP-1:0] port_power_req_i,
  input  wire [NP-1:0] port_active_i,
  input  wire          suspend_i,
  input  wire          global_oc_mode_i,
  output reg           self_powered_o,
  output reg  [NP-1:0] overcurrent_o,
  output reg  [NP-1:0] nonremovable_o,
  output reg  [2:0]    port_count_o,
  output reg           ganged_o,
  output reg           rom_mode_o,
  output reg           cfg_valid_o,
  output reg  [15:0]   vendor_id_o,
  output reg  [15:0]   product_id_o,
  output reg  [15:0]   unique_id_o,
  output reg  [15:0]   hub_cfg_o
);
  // two-flop synchronisers for all pin inputs
  // system pins first, then port pins, straps and the rom data line
  localparam SW = 2*NP + 4;
  reg  [SW-1:0] s1_ff;
  reg  [SW-1:0] s2_ff;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_ff <= {SW{1'b1}};
      s2_ff <= {SW{1'b1}};
    end else if (ce_i) begin
      s1_ff <= {power_mode_select_i,
                upstream_vbus_monitor_i,
                overcurrent_in_n_i,
                power_strap_i,
                rom_cs_strap_i,
                rom_data_in_i};
      s2_ff <= s1_ff;
    end
  end
  wire          bus_sel  = s2_ff[SW-1];
  wire          vbus_s   = s2_ff[SW-2];
  wire [NP-1:0] oc_n_s   = s2_ff[SW-3 -: NP];
  wire [NP-1:0] strap_s  = s2_ff[SW-3-NP -: NP];
  wire          cs_str   = s2_ff[1];
  wire          miso_s   = s2_ff[0];

  // straps tracked while pins float, frozen after release settles;
  // the 2-flop delay means the first captured level is post-release
  reg [2:0]    rel_ff;
  reg          done_ff;
  reg [NP-1:0] nr_ff;
  reg [NP-1:0] pst_ff;
  reg          cs_ff;
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rel_ff <= 3'h0;
      done_ff <= 1'b0;
      nr_ff <= {NP{1'b0}};
      pst_ff <= {NP{1'b1}};
      cs_ff <= 1'b1;
    end else if (ce_i) begin
      rel_ff <= {rel_ff[1:0], 1'b1};
      if (!done_ff && rel_ff[2]) begin
        done_ff <= 1'b1;
        nr_ff <= ~oc_n_s;
        pst_ff <= strap_s;
        cs_ff <= cs_str;
      end
    end
  end

  // decoded configuration
  wire [2:0] nports = (pst_ff[3:2] == 2'b11) ? 3'd4 :
                      (pst_ff[3:2] == 2'b10) ? 3'd3 : 3'd2;
  wire gang   = ~pst_ff[1];
  wire clk_en = ~pst_ff[0];
  wire romsel = ~cs_ff;
  // self powered only with the select high and vbus present
  wire selfp  = bus_sel & vbus_s;

  // rom reader instance, started once after strap capture in rom mode
  reg         rstart_ff;
  wire        rbusy, rvld, rsck, rcs, rmosi;
  wire [3:0]  ridx;
  wire [15:0] rword;
  hpc_rom_reader #(.WORDS(`HPC_ROM_WORDS), .AW(4)) u_rom (
    .mclk_i     (mclk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .start_i    (rstart_ff),
    .busy_o     (rbusy),
    .word_vld_o (rvld),
    .word_idx_o (ridx),
    .word_o     (rword),
    .sck_o      (rsck),
    .cs_n_o     (rcs),
    .mosi_o     (rmosi),
    .miso_i     (miso_s)
  );

  // device clock divider for 24 or 12 MHz equivalent
  reg [1:0]  cdiv_ff;
  reg        nclk_ff;
  wire [1:0] cdiv_top = hub_cfg_o[0] ? `HPC_CLK_DIV_12 : `HPC_CLK_DIV_24;

  // the divider runs only once straps are frozen, so a strapped-off
  // clock output never toggles the shared system pin during boot
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cdiv_ff <= 2'h0;
      nclk_ff <= 1'b0;
    end else if (ce_i && done_ff) begin
      if (cdiv_ff >= cdiv_top - 2'h1) begin
        cdiv_ff <= 2'h0;
        nclk_ff <= ~nclk_ff;
      end else begin
        cdiv_ff <= cdiv_ff + 2'h1;
      end
    end
  end

  // per-port enable mask; ports at or above the count stay dark
  wire [NP-1:0] en_mask;
  wire [NP-1:0] oc_any;
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_port
      assign en_mask[g] = (g < nports);
    end
  endgenerate
  // global mode spreads any enabled port's fault to every enabled port
  assign oc_any = {NP{|(~oc_n_s & en_mask)}};

  // main registered outputs
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      power_enable_n_o <= {NP{1'b1}};
      power_enable_oe_o <= {NP{1'b0}};
      rom_chip_select_n_o <= 1'b1;
      rom_chip_select_oe_o <= 1'b0;
      rom_serial_clock_o <= 1'b0;
      rom_data_out_o <= 1'b0;
      port_led_n_o <= {NP{1'b1}};
      sys_suspend_clk_o <= 1'b0;
      self_powered_o <= 1'b0;
      overcurrent_o <= {NP{1'b0}};
      nonremovable_o <= {NP{1'b0}};
      port_count_o <= 3'd0;
      ganged_o <= 1'b0;
      rom_mode_o <= 1'b0;
      cfg_valid_o <= 1'b0;
      vendor_id_o <= 16'h0000;
      product_id_o <= 16'h0000;
      unique_id_o <= 16'h0000;
      hub_cfg_o <= 16'h0000;
      rstart_ff <= 1'b0;
    end else if (ce_i) begin
      rstart_ff <= 1'b0;
      if (done_ff) begin
        // pins stay released until straps are frozen
        power_enable_oe_o <= {NP{1'b1}};
        rom_chip_select_oe_o <= 1'b1;
        self_powered_o <= selfp;
        nonremovable_o <= nr_ff & en_mask;
        port_count_o <= nports;
        ganged_o <= gang;
        rom_mode_o <= romsel;
        overcurrent_o <= (global_oc_mode_i ? oc_any
                                           : ~oc_n_s) & en_mask;
        // low turns vbus on; ganged follows port 1 request
        power_enable_n_o <= ~((gang ? {NP{port_power_req_i[0]}}
                                    : port_power_req_i) & en_mask);
        if (romsel) begin
          // one read per boot; the valid flag blocks a second fetch
          if (!cfg_valid_o && !rbusy && !rstart_ff && !rvld)
            rstart_ff <= 1'b1;
          rom_serial_clock_o <= rsck;
          rom_chip_select_n_o <= rcs;
          rom_data_out_o <= rmosi;
          port_led_n_o <= {{(NP-1){1'b1}}, ~suspend_i};
        end else begin
          rom_chip_select_n_o <= 1'b1;
          rom_serial_clock_o <= 1'b0;
          rom_data_out_o <= 1'b0;
          port_led_n_o <= ~(port_active_i & en_mask);
          // nothing to fetch in led mode, the ids keep their zeros
          cfg_valid_o <= 1'b1;
        end
        // words past the four known slots are read and dropped
        if (rvld) begin
          case (ridx)
            `HPC_VID_IDX: vendor_id_o <= rword;
            `HPC_PID_IDX: product_id_o <= rword;
            `HPC_UID_IDX: unique_id_o <= rword;
            `HPC_CFG_IDX: hub_cfg_o <= rword;
            default: ;
          endcase
          if (ridx == `HPC_ROM_WORDS - 1) cfg_valid_o <= 1'b1;
        end
        // system pin: device clock when strapped, else suspend
        sys_suspend_clk_o <= clk_en ? nclk_ff : suspend_i;
      end
    end
  end
endmodule

// file: verilog/hpc_rom_reader.v
`include "hpc_map.vh"
// spi master: one read command, then a stream of 16-bit words
module hpc_rom_reader #(
  parameter WORDS = `HPC_ROM_WORDS,
  parameter AW    = 4
) (
  // clock and reset
  input  wire          mclk_i,
  input  wire          reset_n_i,
  input  wire          ce_i,
  // control
  input  wire          start_i,
  output reg           busy_o,
  output reg           word_vld_o,
  output reg  [AW-1:0] word_idx_o,
  output reg  [15:0]   word_o,
  // spi pins
  output reg           sck_o,
  output reg           cs_n_o,
  output reg           mosi_o,
  input  wire          miso_i
);
  localparam S_IDLE = 3'b001;
  localparam S_CMD  = 3'b010;
  localparam S_DATA = 3'b100;
  reg [2:0]  st_ff;
  reg [7:0]  div_ff;
  reg [31:0] sh_ff;
  reg [4:0]  bit_ff;
  reg [AW:0] cnt_ff;
  wire tick = (div_ff == `HPC_SCK_DIV - 1);
  // spi mode 0: shift out on falling edge, sample on rising edge
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= S_IDLE;
      div_ff <= 8'h00;
      sh_ff <= 32'h0000_0000;
      bit_ff <= 5'h00;
      cnt_ff <= {(AW+1){1'b0}};
      busy_o <= 1'b0;
      word_vld_o <= 1'b0;
      word_idx_o <= {AW{1'b0}};
      word_o <= 16'h0000;
      sck_o <= 1'b0;
      cs_n_o <= 1'b1;
      mosi_o <= 1'b0;
    end else if (ce_i) begin
      word_vld_o <= 1'b0;
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
      case (st_ff)
        S_IDLE: begin
          if (start_i) begin
            st_ff <= S_CMD;
            busy_o <= 1'b1;
            cs_n_o <= 1'b0;
            sh_ff <= {`HPC_ROM_CMD_READ, 24'h000000};
            // the read command's top bit is zero, so the line starts low
            mosi_o <= 1'b0;
            bit_ff <= 5'h1f;
            div_ff <= 8'h00;
            cnt_ff <= {(AW+1){1'b0}};
          end
        end
        S_CMD, S_DATA: if (tick) begin
          sck_o <= ~sck_o;
          if (!sck_o) begin
            // rising edge: sample rom data
            sh_ff <= {sh_ff[30:0], miso_i};
            if (bit_ff == 5'h00) begin
              if (st_ff == S_CMD) begin
                st_ff <= S_DATA;
                bit_ff <= 5'h0f;
              end else begin
                word_vld_o <= 1'b1;
                word_o <= {sh_ff[14:0], miso_i};
                word_idx_o <= cnt_ff[AW-1:0];
                cnt_ff <= cnt_ff + 1'b1;
                bit_ff <= 5'h0f;
                if (cnt_ff == WORDS - 1) begin
                  st_ff <= S_IDLE;
                  cs_n_o <= 1'b1;
                  busy_o <= 1'b0;
                  sck_o <= 1'b0;
                end
              end
            end else begin
              bit_ff <= bit_ff - 5'h01;
            end
          end else begin
            mosi_o <= (st_ff == S_CMD) ? sh_ff[31] : 1'b0;
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule
